/* rtl/sdmc_top.sv */
// Supply state sequencer, diagnostic mode and self-test slot control
//
// Functional notes
// [R1] Below switch-off: set low-voltage bit, diagnose
// [R2] Above overvoltage threshold: enter diagnostic mode
// [R3] Startup in SENT mode: output stage released
// [R4] Power-on reset: circuits held, output low
// [R5] Initialization: copy memory to shadow, output low
// [R6] SENT: hold high 100 us before transmitting
// [R7] Overvoltage: core runs, others off, output low
// [R8] Supply diagnosis entered within 20..120 us
// [R9] Checksum/double-bit: diagnose until reset, selectable level
// [R10] Checksum/double-bit status bits sticky until reset
// [R11] Oscillator fault sets control bit seven, diagnoses
// [R12] Four-bit counter gives one slot per test
// [R13] Global self-test enable plus per-test enables
// [R14] Test ready clears its start trigger
// [R15] Trigger never cleared: force diagnostic mode
// [R16] Diagnostic sets status nibble bit 0 unless masked
// [R17] Diagnostic fast channel value by format
// [R18] Encoded state from synchronized comparator flags
// [R19] Diagnosis is OR of faults, latched until reset; code latches only memory and handshake faults
`include "sdmc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module sdmc_top #(
	parameter int NUM_TESTS = 16,
	parameter int SLOT_DIV = `SDMC_SLOT_DIV
) (
	input wire logic sys_clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic cmp_por_ok, // Supply above reset level
	input wire logic cmp_startup_ok, // Supply above startup level
	input wire logic cmp_on_ok, // Supply above switch-on threshold
	input wire logic cmp_off_low, // Supply below switch-off threshold
	input wire logic cmp_ov_high, // Supply above overvoltage threshold
	input wire logic cmp_norm_ok, // Supply inside normal range
	input wire logic csum_err, // Memory checksum error
	input wire logic dbe_err, // Memory double-bit error
	input wire logic osc_err, // Oscillator fault
	input wire logic copy_done, // Shadow copy finished
	input wire logic [NUM_TESTS-1:0] test_enable, // Per-test enables
	input wire logic [NUM_TESTS-1:0] test_ready, // Per-test ready
	input wire logic [11:0] angle_in, // Angle value
	input wire logic [3:0] status_in, // Status nibble in
	output logic [NUM_TESTS-1:0] test_trigger, // Start triggers
	output logic copy_start, // Shadow copy request
	output logic core_run, // Digital core enable
	output logic analog_run, // Analog circuits enable
	output logic out_o, // Output pin value
	output logic out_oe, // Output pin enable
	output logic sent_go, // SENT transmission allowed
	output logic diag_mode, // Diagnostic mode
	output logic diag_high, // Diagnostic high level
	output logic [3:0] status_out, // Status nibble out
	output logic [11:0] fast_value, // Fast channel value
	output logic irq, // Interrupt level
	input wire logic [3:0] avs_address, // Byte address
	input wire logic avs_read, // Read strobe
	input wire logic avs_write, // Write strobe
	input wire logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest // Wait request
);
	// ------------------------------------------------------------------
	// Timing constants
	// ------------------------------------------------------------------
	localparam int SENT_HIGH_CYC = `SDMC_SENT_HIGH_US * `SDMC_CLK_MHZ;
	localparam int DIAG_MIN_CYC = `SDMC_DIAG_MIN_US * `SDMC_CLK_MHZ;
	localparam int DIAG_MAX_CYC = `SDMC_DIAG_MAX_US * `SDMC_CLK_MHZ;
	// Filter length sits mid window
	localparam int FILT_CYC = (DIAG_MIN_CYC + DIAG_MAX_CYC) / 2;
	localparam int DIAG_HI = 15000;
	localparam int NE = `SDMC_NUM_EV;

	// ------------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------------
	localparam int NS = 10;
	logic [NS-1:0] raw_in; // Async inputs
	logic [NS-1:0] sy1_ff; // First stage
	logic [NS-1:0] sy2_ff; // Second stage
	assign raw_in = {copy_done, osc_err, dbe_err, csum_err, cmp_norm_ok,
		cmp_ov_high, cmp_off_low, cmp_on_ok, cmp_startup_ok, cmp_por_ok};
	// Two-stage capture of comparator and fault flags
	always_ff @(posedge sys_clk or negedge nrst) begin // see [R18]
		if (!nrst) begin
			sy1_ff <= '0;
			sy2_ff <= '0;
		end else begin
			sy1_ff <= raw_in;
			sy2_ff <= sy1_ff;
		end
	end
	wire s_por = sy2_ff[0];
	wire s_start = sy2_ff[1];
	wire s_on = sy2_ff[2];
	wire s_low = sy2_ff[3];
	wire s_ov = sy2_ff[4];
	wire s_norm = sy2_ff[5];
	wire s_csum = sy2_ff[6];
	wire s_dbe = sy2_ff[7];
	wire s_osc = sy2_ff[8];
	wire s_copy = sy2_ff[9];

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [NE-1:0] status_ff; // Sticky events
	logic [NE-1:0] mask_ff; // Interrupt mask
	logic [7:0] config_ff; // b0 sent, b1 diag high, b2 glb test, b3 msk
	logic [2:0] fmt_ff; // Protocol format
	logic [7:0] control_register_one_ff; // Control register one
	wire cfg_sent = config_ff[0];
	wire cfg_diag_hi = config_ff[1];
	wire cfg_bist = config_ff[2];
	wire cfg_mask_b0 = config_ff[3];

	// ------------------------------------------------------------------
	// Supply sequencer
	// ------------------------------------------------------------------
	sdmc_pkg::sdmc_state_e state_ff, nxt_state;
	logic [15:0] filt_ff; // Supply fault filter
	wire supply_bad = s_low | s_ov;
	wire filt_done = (filt_ff == 16'(FILT_CYC));
	// Count while the supply fault persists
	always_ff @(posedge sys_clk or negedge nrst) begin // see [R8]
		if (!nrst)
			filt_ff <= '0;
		else if (!supply_bad)
			filt_ff <= '0;
		else if (!filt_done)
			filt_ff <= filt_ff + 16'h0001;
	end
	wire low_diag = s_low & filt_done; // see [R1]
	wire ov_diag = s_ov & filt_done; // see [R2]
	// Next state choice from supply levels
	always_comb begin // see [R18]
		nxt_state = state_ff;
		case (state_ff)
		sdmc_pkg::SDMC_STARTUP:
			if (s_start) nxt_state = sdmc_pkg::SDMC_POR;
		sdmc_pkg::SDMC_POR:
			if (!s_start) nxt_state = sdmc_pkg::SDMC_STARTUP;
			else if (s_por) nxt_state = sdmc_pkg::SDMC_INIT;
		sdmc_pkg::SDMC_INIT:
			if (!s_por) nxt_state = sdmc_pkg::SDMC_POR;
			else if (s_copy && s_on) nxt_state = sdmc_pkg::SDMC_FUNC;
		sdmc_pkg::SDMC_FUNC:
			if (!s_por) nxt_state = sdmc_pkg::SDMC_POR;
			else if (ov_diag) nxt_state = sdmc_pkg::SDMC_OVERV;
			else if (s_norm) nxt_state = sdmc_pkg::SDMC_NORMAL;
		sdmc_pkg::SDMC_NORMAL:
			if (!s_por) nxt_state = sdmc_pkg::SDMC_POR;
			else if (ov_diag) nxt_state = sdmc_pkg::SDMC_OVERV;
			else if (!s_norm) nxt_state = sdmc_pkg::SDMC_FUNC;
		sdmc_pkg::SDMC_OVERV:
			if (!s_por) nxt_state = sdmc_pkg::SDMC_POR;
			else if (!s_ov) nxt_state = sdmc_pkg::SDMC_FUNC;
		default:
			nxt_state = sdmc_pkg::SDMC_STARTUP;
		endcase
	end
	// State register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			state_ff <= sdmc_pkg::SDMC_STARTUP;
		else
			state_ff <= nxt_state;
	end
	wire st_start = (state_ff == sdmc_pkg::SDMC_STARTUP);
	wire st_por = (state_ff == sdmc_pkg::SDMC_POR);
	wire st_init = (state_ff == sdmc_pkg::SDMC_INIT);
	wire st_ov = (state_ff == sdmc_pkg::SDMC_OVERV);
	wire st_run = (state_ff == sdmc_pkg::SDMC_FUNC) |
		(state_ff == sdmc_pkg::SDMC_NORMAL);

	// ------------------------------------------------------------------
	// SENT start delay
	// ------------------------------------------------------------------
	logic [15:0] hold_ff; // High time counter
	wire hold_done = (hold_ff == 16'(SENT_HIGH_CYC));
	// Count high time after entering operation
	always_ff @(posedge sys_clk or negedge nrst) begin // see [R6]
		if (!nrst)
			hold_ff <= '0;
		else if (!st_run)
			hold_ff <= '0;
		else if (!hold_done)
			hold_ff <= hold_ff + 16'h0001;
	end

	// ------------------------------------------------------------------
	// Self-test slot sequencer
	// ------------------------------------------------------------------
	logic [15:0] div_ff; // Slot tick divider
	logic [3:0] slot_ff; // Time slot counter
	logic [7:0] wait_ff; // Ready timeout counter
	logic hsk_ff; // Handshake fault latch
	wire slot_tick = (div_ff == 16'(SLOT_DIV - 1));
	wire tests_on = cfg_bist & st_run; // see [R13]
	// Divider gives the slot enable pulse
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			div_ff <= '0;
		else
			div_ff <= slot_tick ? 16'h0000 : div_ff + 16'h0001;
	end
	// Four-bit up-counter steps through slots
	always_ff @(posedge sys_clk or negedge nrst) begin // see [R12]
		if (!nrst)
			slot_ff <= '0;
		else if (tests_on && slot_tick)
			slot_ff <= slot_ff + 4'h1;
	end
	// Per-test trigger set at slot start, cleared by ready
	genvar g;
	generate
		for (g = 0; g < NUM_TESTS; g++) begin : g_trig
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst)
					test_trigger[g] <= 1'b0;
				else if (test_ready[g])
					test_trigger[g] <= 1'b0; // see [R14]
				else if (tests_on && test_enable[g] && slot_tick &&
					(slot_ff == 4'(g)))
					test_trigger[g] <= 1'b1; // see [R12]
			end
		end
	endgenerate
	wire trig_any = |test_trigger;
	// Timeout on an uncleared trigger
	always_ff @(posedge sys_clk or negedge nrst) begin // see [R15]
		if (!nrst) begin
			wait_ff <= '0;
			hsk_ff <= 1'b0;
		end else if (!trig_any) begin
			wait_ff <= '0;
		end else if (slot_tick) begin
			if (wait_ff == `SDMC_TEST_TIMEOUT)
				hsk_ff <= 1'b1;
			else
				wait_ff <= wait_ff + 8'h01;
		end
	end

	// ------------------------------------------------------------------
	// Diagnostic decision
	// ------------------------------------------------------------------
	logic csum_lat_ff; // Checksum latch
	logic dbe_lat_ff; // Double-bit latch
	// Latched memory faults kept until reset
	always_ff @(posedge sys_clk or negedge nrst) begin // see [R9]
		if (!nrst) begin
			csum_lat_ff <= 1'b0;
			dbe_lat_ff <= 1'b0;
		end else begin
			csum_lat_ff <= csum_lat_ff | s_csum;
			dbe_lat_ff <= dbe_lat_ff | s_dbe;
		end
	end
	wire mem_diag = csum_lat_ff | dbe_lat_ff;
	wire nxt_diag = low_diag | ov_diag | mem_diag | s_osc | hsk_ff; // see [R19]
	wire [NE-1:0] ev = {s_osc, hsk_ff, s_dbe, s_csum, ov_diag, low_diag};
	// Outputs of the diagnostic path
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			diag_mode <= 1'b0;
			diag_high <= 1'b0;
		end else begin
			diag_mode <= nxt_diag;
			diag_high <= mem_diag & cfg_diag_hi; // see [R9]
		end
	end

	// ------------------------------------------------------------------
	// Pin shaping
	// ------------------------------------------------------------------
	logic nxt_o, nxt_oe;
	// Output level per supply state and mode
	always_comb begin
		nxt_o = 1'b0;
		nxt_oe = 1'b1;
		if (st_start) begin
			nxt_oe = !cfg_sent; // see [R3]
		end else if (st_por || st_init || st_ov) begin
			nxt_o = 1'b0; // see [R4] see [R5] see [R7]
		end else if (nxt_diag) begin
			nxt_o = mem_diag & cfg_diag_hi; // see [R9]
		end else if (cfg_sent && !hold_done) begin
			nxt_o = 1'b1; // see [R6]
		end else begin
			nxt_o = 1'b1;
		end
	end
	wire [11:0] diag_fc = (fmt_ff == sdmc_pkg::SDMC_FMT_A1) ? `SDMC_FC_A1 :
		(fmt_ff == sdmc_pkg::SDMC_FMT_A3) ? angle_in : `SDMC_FC_H;
	// Pin, power and SENT frame outputs
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			out_o <= 1'b0;
			out_oe <= 1'b0;
			copy_start <= 1'b0;
			core_run <= 1'b0;
			analog_run <= 1'b0;
			sent_go <= 1'b0;
			status_out <= '0;
			fast_value <= '0;
		end else begin
			out_o <= nxt_o;
			out_oe <= nxt_oe;
			copy_start <= st_init; // see [R5]
			core_run <= st_init | st_run | st_ov; // see [R7]
			analog_run <= st_run; // see [R4]
			sent_go <= cfg_sent & st_run & hold_done; // see [R6]
			status_out <= {status_in[3:1],
				nxt_diag & !cfg_mask_b0}; // see [R16]
			fast_value <= nxt_diag ? diag_fc : angle_in; // see [R17]
		end
	end

	// ------------------------------------------------------------------
	// Register slave
	// ------------------------------------------------------------------
	wire wr = avs_write & !avs_waitrequest;
	wire rd = avs_read & avs_waitrequest;
	wire hit_st = (avs_address == `SDMC_ADDR_STATUS);
	wire hit_mk = (avs_address == `SDMC_ADDR_MASK);
	wire hit_c1 = (avs_address == `SDMC_ADDR_CONTROL_REGISTER_ONE);
	wire hit_cf = (avs_address == `SDMC_ADDR_CONFIG);
	wire [NE-1:0] w1c = (wr && hit_st) ? avs_writedata[NE-1:0] : '0;
	// Memory fault bits never clear by software
	wire [NE-1:0] keep = (NE)'(1 << `SDMC_ST_CSUM) |
		(NE)'(1 << `SDMC_ST_DBE); // see [R10]
	logic [31:0] rdata;
	always_comb begin
		if (hit_st) rdata = 32'(status_ff);
		else if (hit_mk) rdata = 32'(mask_ff);
		else if (hit_c1) rdata = 32'(control_register_one_ff);
		else if (hit_cf) rdata = {24'h000000, config_ff[7:3], fmt_ff};
		else rdata = 32'h00000000;
	end
	// One wait state then acknowledge
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end else begin
			avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
			if (rd) avs_readdata <= rdata;
		end
	end
	// Status set wins over write-one clear
	always_ff @(posedge sys_clk or negedge nrst) begin // see [R10]
		if (!nrst)
			status_ff <= '0;
		else
			status_ff <= ev | (status_ff & ~(w1c & ~keep));
	end
	// Control register one, oscillator fault bit
	always_ff @(posedge sys_clk or negedge nrst) begin // see [R11]
		if (!nrst)
			control_register_one_ff <= '0;
		else if (s_osc)
			control_register_one_ff[`SDMC_CONTROL_REGISTER_ONE_OSC] <= 1'b1;
		else if (wr && hit_c1 && avs_writedata[`SDMC_CONTROL_REGISTER_ONE_OSC])
			control_register_one_ff[`SDMC_CONTROL_REGISTER_ONE_OSC] <= 1'b0;
	end
	// Mask, config and format writes
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mask_ff <= '0;
			config_ff <= `SDMC_CONFIG_RST;
			fmt_ff <= sdmc_pkg::SDMC_FMT_A1;
			irq <= 1'b0;
		end else begin
			if (wr && hit_mk) mask_ff <= avs_writedata[NE-1:0];
			if (wr && hit_cf) begin
				config_ff <= avs_writedata[10:3];
				fmt_ff <= avs_writedata[2:0];
			end
			irq <= |(status_ff & mask_ff);
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence s_mem_fault;
		s_csum || s_dbe;
	endsequence
	a_mem_fault_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_mem_fault |-> ##2 diag_mode [*8]) // see [R9]
		else $error("memory fault did not hold diagnosis");
	logic [15:0] low_wait_ff; // Low supply cycles without diagnosis
	// Helper count bounds the low voltage entry time
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			low_wait_ff <= '0;
		else if (!s_low || diag_mode)
			low_wait_ff <= '0;
		else if (low_wait_ff != 16'(DIAG_HI))
			low_wait_ff <= low_wait_ff + 16'h0001;
	end
	a_low_enter_time: assert property (@(posedge sys_clk) disable iff (!nrst)
		low_wait_ff < 16'(DIAG_HI)) // see [R8]
		else $error("low voltage diagnosis late");
	a_low_sets_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
		low_diag |=> status_ff[`SDMC_ST_LOWV]) // see [R1]
		else $error("low voltage bit not set");
	a_ov_output_low: assert property (@(posedge sys_clk) disable iff (!nrst)
		st_ov |=> (!out_o && out_oe)) // see [R7]
		else $error("overvoltage output not low");
	a_por_output_low: assert property (@(posedge sys_clk) disable iff (!nrst)
		(st_por || st_init) |=> (!out_o && !analog_run)) // see [R4]
		else $error("reset state output not low");
	a_startup_float: assert property (@(posedge sys_clk) disable iff (!nrst)
		(st_start && cfg_sent) |=> !out_oe) // see [R3]
		else $error("startup SENT output driven");
	a_sent_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(sent_go) |-> $past(hold_ff) >= 16'(SENT_HIGH_CYC - 1)) // see [R6]
		else $error("SENT started too early");
	a_osc_ctrl_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_osc |=> (control_register_one_ff[`SDMC_CONTROL_REGISTER_ONE_OSC] && diag_mode)) // see [R11]
		else $error("oscillator fault not flagged");
	a_ready_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
		test_ready[0] |=> !test_trigger[0]) // see [R14]
		else $error("ready did not clear trigger");
	a_csum_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
		status_ff[`SDMC_ST_CSUM] |=> status_ff[`SDMC_ST_CSUM]) // see [R10]
		else $error("checksum bit cleared");
	a_hsk_diag: assert property (@(posedge sys_clk) disable iff (!nrst)
		hsk_ff |=> diag_mode) // see [R15]
		else $error("handshake fault not diagnosed");
	a_status_bit0: assert property (@(posedge sys_clk) disable iff (!nrst)
		(nxt_diag && !cfg_mask_b0) |=> status_out[0]) // see [R16]
		else $error("status nibble bit 0 not set");
endmodule
`default_nettype wire

/* common/sdmc_params.svh */
// Constants of the supply and diagnostic mode controller
`ifndef SDMC_PARAMS_SVH
`define SDMC_PARAMS_SVH
// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define SDMC_CLK_MHZ 125
`define SDMC_SENT_HIGH_US 100
`define SDMC_DIAG_MIN_US 20
`define SDMC_DIAG_MAX_US 120
// Self-test ready timeout in slot ticks
`define SDMC_TEST_TIMEOUT 8'hC8
// Slot tick divider
`define SDMC_SLOT_DIV 16'h0400
// ----------------------------------------------------------------------
// Register map (word byte addresses)
// ----------------------------------------------------------------------
`define SDMC_ADDR_STATUS 4'h0
`define SDMC_ADDR_MASK 4'h4
`define SDMC_ADDR_CONTROL_REGISTER_ONE 4'h8
`define SDMC_ADDR_CONFIG 4'hC
// Status bit positions
`define SDMC_ST_LOWV 0
`define SDMC_ST_OVV 1
`define SDMC_ST_CSUM 2
`define SDMC_ST_DBE 3
`define SDMC_ST_HSK 4
`define SDMC_ST_OSC 5
`define SDMC_NUM_EV 6
// Control register one oscillator fault bit
`define SDMC_CONTROL_REGISTER_ONE_OSC 7
// Config register reset value
`define SDMC_CONFIG_RST 8'h01
// Fast channel diagnostic values
`define SDMC_FC_A1 12'hFFF
`define SDMC_FC_H 12'hFFA
`endif

/* common/sdmc_pkg.sv */
// Types of the supply and diagnostic mode controller
package sdmc_pkg;
	// Supply sequencer states, one-hot
	typedef enum logic [5:0] {
		SDMC_STARTUP = 6'h01,
		SDMC_POR = 6'h02,
		SDMC_INIT = 6'h04,
		SDMC_FUNC = 6'h08,
		SDMC_NORMAL = 6'h10,
		SDMC_OVERV = 6'h20
	} sdmc_state_e;
	// Protocol formats
	typedef enum logic [2:0] {
		SDMC_FMT_A1 = 3'h0,
		SDMC_FMT_A3 = 3'h1,
		SDMC_FMT_H1 = 3'h2,
		SDMC_FMT_H3 = 3'h3,
		SDMC_FMT_H4 = 3'h4
	} sdmc_fmt_e;
endpackage

/* sim/sdmc_sent_rx.sv */
// Receiving control unit model: output line with pull-up
`timescale 1ns/1ps
`default_nettype none
module sdmc_sent_rx (
	input wire logic out_o, // Pin value from device
	input wire logic out_oe, // Pin drive enable
	output logic line // Resolved line level
);
	// Released pin floats to the pull-up level
	assign line = out_oe ? out_o : 1'b1;
endmodule
`default_nettype wire

/* sim/sdmc_top_tb_top.sv */
// Self-checking bench of the supply and diagnostic controller
`timescale 1ns/1ps
`default_nettype none
module sdmc_top_tb_top;
	// ----------------------------------------------------------
	// Signals
	// ----------------------------------------------------------
	localparam int SD = 8; // Short slot divider
	logic sys_clk, nrst, cmp_por_ok, cmp_startup_ok, cmp_on_ok;
	logic cmp_off_low, cmp_ov_high, cmp_norm_ok, csum_err, dbe_err;
	logic osc_err, copy_done, avs_read, avs_write, copy_start;
	logic core_run, analog_run, out_o, out_oe, sent_go, diag_mode;
	logic diag_high, irq, avs_waitrequest, line;
	logic [15:0] test_enable, test_ready, test_trigger, hold, tprev, both;
	logic [11:0] angle_in, fast_value; // Angle in, channel out
	logic [3:0] status_in, status_out, avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd, seed;
	logic [3:0] ra [4] = '{4'h0, 4'h4, 4'h8, 4'h2}; // Reset read list
	int err_count, total_checks, cyc, n, nq;
	int q[$]; // Order of started self-tests
	// Design under test
	sdmc_top #(.NUM_TESTS(16), .SLOT_DIV(SD)) uut (.sys_clk, .nrst,
		.cmp_por_ok, .cmp_startup_ok, .cmp_on_ok, .cmp_off_low,
		.cmp_ov_high, .cmp_norm_ok, .csum_err, .dbe_err, .osc_err,
		.copy_done, .test_enable, .test_ready, .angle_in, .status_in,
		.test_trigger, .copy_start, .core_run, .analog_run, .out_o,
		.out_oe, .sent_go, .diag_mode, .diag_high, .status_out,
		.fast_value, .irq, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest);
	// Receiving control unit
	sdmc_sent_rx rx (.out_o, .out_oe, .line);
	// Clock of 8 ns
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// ----------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------
	// Compare and count
	task automatic chk(input logic [31:0] seen, exp, input string m);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s seen %0h expected %0h",
				$time, m, seen, exp);
		end
	endtask
	// Counts and verdict
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Cycle ceiling and self-test responder
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 99000) begin
			err_count++;
			report_and_stop();
		end
		for (int i = 0; i < 16; i++) begin
			if (test_trigger[i] === 1'b1 && tprev[i] !== 1'b1)
				q.push_back(i);
		end
		// Ready follows trigger unless withheld
		test_ready <= test_trigger & ~hold;
		both <= test_trigger & test_ready;
		tprev <= test_trigger;
		if (nrst === 1'b1)
			chk(|(both & test_trigger & test_ready), 0, "trigger kept");
	end
	// Avalon cycle, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~wr;
		avs_write <= wr;
		do begin
			@(posedge sys_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 64);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
		chk(k < 64, 1, "bus answer");
	endtask
	// Xorshift step onto the data inputs
	task automatic shuffle();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		angle_in <= seed[11:0];
		status_in <= seed[15:12];
	endtask
	// Waits for an output level and checks the delay window
	task automatic wait_on(input int w, input logic v, input int lo, hi,
		input string m);
		logic s;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			case (w)
				0: s = diag_mode;
				1: s = copy_start;
				2: s = out_o;
				3: s = sent_go;
				default: s = out_oe;
			endcase
		end while (s !== v && n <= hi);
		chk(n >= lo && n <= hi, 1, m);
	endtask
	// Expected fast channel value
	function automatic logic [11:0] fv(int f, logic d, logic [11:0] a);
		if (!d || f == 1)
			return a;
		return (f == 0) ? 12'hFFF : 12'hFFA;
	endfunction
	// Next enabled self-test after slot i
	function automatic int nxt(int i);
		for (int j = 1; j <= 16; j++)
			if (test_enable[(i + j) % 16] === 1'b1)
				return (i + j) % 16;
		return -1;
	endfunction
	// Reset and supply ramp through all states except overvoltage
	task automatic power_up(input logic full);
		{cmp_por_ok, cmp_startup_ok, cmp_on_ok, copy_done} <= 4'h0;
		{cmp_off_low, cmp_ov_high, cmp_norm_ok} <= 3'h0;
		{csum_err, dbe_err, osc_err} <= 3'h0;
		nrst <= 1'b0;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk({out_oe, line}, 2'b01, "startup released");
		cmp_startup_ok <= 1'b1;
		wait_on(4, 1'b1, 1, 20, "reset state entry");
		chk({out_o, core_run, analog_run}, 0, "reset state");
		cmp_por_ok <= 1'b1;
		wait_on(1, 1'b1, 1, 20, "init entry");
		chk({out_oe, out_o, core_run}, 3'b101, "init state");
		copy_done <= 1'b1;
		cmp_on_ok <= 1'b1;
		wait_on(2, 1'b1, 1, 20, "functional entry");
		chk({analog_run, sent_go}, 2'b10, "functional state");
		if (full)
			wait_on(3, 1'b1, 12500, 12600, "transmit delay");
		cmp_norm_ok <= 1'b1;
		repeat (8) @(posedge sys_clk);
	endtask
	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial begin
		seed = 32'h048423D0;
		err_count = 0;
		total_checks = 0;
		cyc = 0;
		{hold, tprev, both, test_ready, test_enable} <= 80'h0;
		{angle_in, status_in} <= 16'h0000;
		{avs_read, avs_write, avs_address, avs_writedata} <= 38'h0;
		power_up(1'b1);
		bus(1, 4'h2, 32'hFFFFFFFF);
		foreach (ra[i]) begin
			bus(0, ra[i], 32'h0);
			chk(rd, 32'h0, "reset value");
		end
		bus(1, 4'h4, 32'hFFFFFFFF);
		bus(0, 4'h4, 32'h0);
		chk(rd, 32'h3F, "mask width");
		$display("test power and registers done");
		// Low voltage, with diagnostic values by format
		cmp_off_low <= 1'b1;
		wait_on(0, 1'b1, 2500, 15000, "low voltage entry");
		bus(0, 4'h0, 32'h0);
		chk({rd[0], irq}, 2'b11, "low voltage bit");
		for (int f = 0; f < 5; f++) begin
			for (int m = 0; m < 2; m++) begin
				bus(1, 4'hC, f | 32'h8 | (m << 6));
				shuffle();
				repeat (3) @(posedge sys_clk);
				chk(fast_value, fv(f, 1'b1, angle_in), "fast value");
				chk(status_out[0], m == 0, "status diag bit");
			end
		end
		cmp_off_low <= 1'b0;
		wait_on(0, 1'b0, 1, 15000, "low voltage exit");
		bus(1, 4'h0, 32'h1);
		bus(0, 4'h0, 32'h0);
		chk({rd[0], irq}, 0, "low voltage cleared");
		chk(fast_value, angle_in, "angle passes");
		$display("test low voltage done");
		// Overvoltage with interrupt masked
		bus(1, 4'h4, 32'h0);
		{cmp_ov_high, cmp_norm_ok} <= 2'b10;
		wait_on(0, 1'b1, 2500, 15000, "overvoltage entry");
		repeat (4) @(posedge sys_clk);
		chk({out_oe, out_o, core_run, analog_run}, 4'hA, "ov state");
		bus(0, 4'h0, 32'h0);
		chk({rd[1], irq}, 2'b10, "overvoltage bit");
		{cmp_ov_high, cmp_norm_ok} <= 2'b01;
		wait_on(0, 1'b0, 1, 15000, "overvoltage exit");
		$display("test overvoltage done");
		// Oscillator fault
		osc_err <= 1'b1;
		wait_on(0, 1'b1, 1, 40, "oscillator diag");
		osc_err <= 1'b0;
		bus(0, 4'h8, 32'h0);
		chk(rd[7], 1, "oscillator flag");
		bus(1, 4'h8, 32'h80);
		bus(1, 4'h0, 32'h3F);
		bus(0, 4'h8, 32'h0);
		chk(rd[7], 0, "oscillator flag clear");
		$display("test oscillator done");
		// Self-test slots, then global disable
		test_enable <= seed[31:16] | 16'h0001;
		bus(1, 4'hC, 32'h28);
		q.delete();
		repeat (40 * SD) @(posedge sys_clk);
		chk(q.size() > 2, 1, "slots run");
		chk(test_enable[q[0]], 1, "first slot");
		for (int k = 1; k < q.size(); k++)
			chk(q[k], nxt(q[k - 1]), "slot order");
		chk(diag_mode, 0, "no handshake fault");
		bus(1, 4'hC, 32'h8);
		repeat (2 * SD) @(posedge sys_clk);
		nq = q.size();
		repeat (40 * SD) @(posedge sys_clk);
		chk(q.size(), nq, "global disable");
		$display("test self-test slots done");
		// Memory faults latch until reset
		for (int e = 0; e < 2; e++) begin
			power_up(1'b0);
			bus(1, 4'hC, 32'h8 | ((e == 0) << 4));
			{csum_err, dbe_err} <= (e != 0) ? 2'b01 : 2'b10;
			wait_on(0, 1'b1, 1, 40, "memory fault diag");
			{csum_err, dbe_err} <= 2'b00;
			repeat (50) @(posedge sys_clk);
			chk({diag_mode, diag_high}, {1'b1, e == 0}, "level");
			bus(1, 4'h0, 32'h3F);
			bus(0, 4'h0, 32'h0);
			chk(rd[3:2], (e != 0) ? 2'b10 : 2'b01, "sticky bit");
		end
		$display("test memory faults done");
		// Withheld ready forces latched diagnosis
		power_up(1'b1);
		bus(0, 4'h0, 32'h0);
		chk(rd[5:0], 0, "cleared by reset");
		test_enable <= 16'h0020;
		hold <= 16'h0020;
		bus(1, 4'hC, 32'h28);
		wait_on(0, 1'b1, 200 * SD, 230 * SD, "handshake fault");
		hold <= 16'h0000;
		repeat (100) @(posedge sys_clk);
		bus(0, 4'h0, 32'h0);
		chk({rd[4], diag_mode}, 2'b11, "handshake latched");
		$display("test handshake done");
		report_and_stop();
	end
endmodule
`default_nettype wire
